// ==== hdl/ufa_pkg.sv ====
// Package of register offsets, field positions and reset values for the receive extension.
package ufa_pkg;

	// ======================================================================
	// Register offsets
	localparam logic [7:0] ADDR_SERIAL_CTRL       = 8'h98;
	localparam logic [7:0] ADDR_POWER_CTRL        = 8'h87;
	localparam logic [7:0] ADDR_STATION_ADDRESS   = 8'hA9;
	localparam logic [7:0] ADDR_STATION_ADDR_MASK = 8'hB9;
	localparam logic [7:0] ADDR_PORT2_SERIAL_CTRL = 8'hC0;
	localparam logic [7:0] ADDR_RX_BUFFER         = 8'h99;
	localparam logic [7:0] ADDR_PORT2_RX_BUFFER   = 8'hC1;

	// ======================================================================
	// Field positions
	localparam int BIT_SHARED_VIEW   = 7;
	localparam int BIT_MODE_LOW      = 6;
	localparam int BIT_MULTIPROC     = 5;
	localparam int BIT_RX_NINTH      = 2;
	localparam int BIT_RECEIVE_DONE  = 0;
	localparam int BIT_VIEW_SELECT   = 6;

	// ======================================================================
	// Reset values
	localparam logic [7:0] RST_STATION_ADDRESS   = 8'h00;
	localparam logic [7:0] RST_STATION_ADDR_MASK = 8'h00;
	localparam logic [7:0] RST_SERIAL_CTRL       = 8'h00;
	localparam logic [7:0] RST_POWER_CTRL        = 8'h00;
	localparam logic [7:0] RST_RX_BUFFER         = 8'h00;

	// ======================================================================
	// Mode numbers
	localparam logic [1:0] MODE_SYNC  = 2'h0;
	localparam logic [1:0] MODE_ASYNC = 2'h1;
	localparam logic [1:0] MODE_NINE2 = 2'h2;
	localparam logic [1:0] MODE_NINE3 = 2'h3;

endpackage : ufa_pkg

// ==== hdl/ufa_port_if.sv ====
// Interface between the top and one per-port frame qualifier.
interface ufa_port_if;
	logic       frame_done;
	logic [7:0] frame_data;
	logic       frame_ninth;
	logic       frame_stop;
	logic [1:0] mode;
	logic       multiproc_enable;
	logic       receive_done;
	logic [7:0] station_address;
	logic [7:0] station_address_mask;
	logic       load;
	logic       frame_error;

	modport top (
		output frame_done, frame_data, frame_ninth, frame_stop, mode, multiproc_enable,
		output receive_done, station_address, station_address_mask,
		input  load, frame_error
	);
	modport qual (
		input  frame_done, frame_data, frame_ninth, frame_stop, mode, multiproc_enable,
		input  receive_done, station_address, station_address_mask,
		output load, frame_error
	);
endinterface : ufa_port_if

// ==== hdl/ufa_qualify.sv ====
// Combinational frame qualifier: address recognition and load decision for one port.
module ufa_qualify (
	// Port side
	ufa_port_if.qual p
);
	logic [7:0] bcast;
	logic       given_hit;
	logic       bcast_hit;
	logic       addr_hit;
	logic       cond_ok;
	logic       nine_bit;

	always_comb begin
		bcast     = p.station_address | p.station_address_mask; // RQ12
		given_hit = ((p.frame_data ^ p.station_address) & p.station_address_mask) == 8'h00; // RQ11
		bcast_hit = ((p.frame_data ^ bcast) & bcast) == 8'h00; // RQ12
		addr_hit  = given_hit | bcast_hit; // RQ17
		nine_bit  = (p.mode == ufa_pkg::MODE_NINE2) || (p.mode == ufa_pkg::MODE_NINE3);
		cond_ok   = 1'b1; // RQ9
		if (p.multiproc_enable) begin
			if (nine_bit) begin
				cond_ok = p.frame_ninth & addr_hit; // RQ7 RQ8
			end else if (p.mode == ufa_pkg::MODE_ASYNC) begin
				cond_ok = p.frame_stop & addr_hit; // RQ10
			end
		end
		p.load        = p.frame_done & ~p.receive_done & cond_ok; // RQ15
		p.frame_error = p.frame_done & ~p.frame_stop & (p.mode != ufa_pkg::MODE_SYNC); // RQ1
	end
endmodule : ufa_qualify

// ==== hdl/ufa_rx_ext.sv ====
// Top of the receive extension: frame error flags, shared bit 7 and address recognition.
//
// Implementation choice: the address-and-strobe port.

// Overview of operation
// [RQ1] A frame without a valid stop bit sets the frame error flag; the code sets it in modes 1, 2 and 3 only, not in mode 0.
// [RQ2] Control bit 7 shows frame error when view select is 1, else mode high bit.
// [RQ3] Port two has its own frame error flag sharing its control bit 7.
// [RQ4] Only hardware sets the frame error flag; only a software write clears it.
// [RQ5] A later good frame never clears a set frame error flag.
// [RQ6] Software keeps view select at 1 while accessing either frame error flag.
// [RQ7] In modes 2 and 3 a high ninth bit marks an address byte.
// [RQ8] Multiprocessor on in modes 2 or 3: receive flag only on address match.
// [RQ9] Multiprocessor off: every complete frame sets the receive flag.
// [RQ10] Mode 1 with multiprocessor on: needs valid stop bit and address match.
// [RQ11] Given address compares only station bits whose mask bit is 1.
// [RQ12] Broadcast address is station OR mask; its zero bits are don't care.
// [RQ13] Reset clears station address and mask to zero, so everything matches.
// [RQ14] Station address sits at A9h, its mask at B9h.
// [RQ15] Load buffer, ninth bit and receive flag only if flag clear and condition met.
// [RQ16] Nine-bit modes store the received ninth bit in the control register.
// [RQ17] Compare eight data bits against given and broadcast; either match qualifies.
module ufa_rx_ext #(
	parameter int PORTS = 2
) (
	// Clock and reset
	input  wire logic            clk_sys,
	input  wire logic            rst,
	// Register port
	input  wire logic [7:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic      [7:0]      reg_rdata,
	// Frames from the receive engines, one lane per port
	input  wire logic [PORTS-1:0]   frame_done,
	input  wire logic [PORTS*8-1:0] frame_data,
	input  wire logic [PORTS-1:0]   frame_ninth,
	input  wire logic [PORTS-1:0]   frame_stop,
	// Status toward the rest of the port
	output logic      [PORTS-1:0]   receive_done_flag,
	output logic      [PORTS-1:0]   frame_error_flag,
	output logic      [PORTS*2-1:0] serial_mode
);
	if (PORTS != 2) begin : g_bad_ports
		$error("ufa_rx_ext serves exactly two serial ports");
	end

	// ======================================================================
	// State
	logic [7:0]       station_address_q, station_address_d;
	logic [7:0]       station_address_mask_q, station_address_mask_d;
	logic [7:0]       power_ctrl_q, power_ctrl_d;
	logic [7:0]       ctrl_q [PORTS], ctrl_d [PORTS];
	logic [7:0]       rxbuf_q [PORTS], rxbuf_d [PORTS];
	logic [PORTS-1:0] mode_high_q, mode_high_d;
	logic [PORTS-1:0] ferr_q, ferr_d;
	logic [7:0]       rdata_q, rdata_d;
	logic [PORTS-1:0] load;
	logic [PORTS-1:0] ferr_set;
	logic             view_fe;

	assign view_fe = power_ctrl_q[ufa_pkg::BIT_VIEW_SELECT]; // RQ6

	// ======================================================================
	// Per-port qualifiers
	for (genvar i = 0; i < PORTS; i++) begin : g_port
		ufa_port_if pif ();
		assign pif.frame_done           = frame_done[i];
		assign pif.frame_data           = frame_data[i*8 +: 8];
		assign pif.frame_ninth          = frame_ninth[i];
		assign pif.frame_stop           = frame_stop[i];
		assign pif.mode                 = {mode_high_q[i], ctrl_q[i][ufa_pkg::BIT_MODE_LOW]};
		assign pif.multiproc_enable     = ctrl_q[i][ufa_pkg::BIT_MULTIPROC];
		assign pif.receive_done         = ctrl_q[i][ufa_pkg::BIT_RECEIVE_DONE];
		assign pif.station_address      = station_address_q;
		assign pif.station_address_mask = station_address_mask_q;
		assign load[i]                  = pif.load;
		assign ferr_set[i]              = pif.frame_error;
		ufa_qualify u_qual (
			.p (pif.qual)
		);
		assign receive_done_flag[i]     = ctrl_q[i][ufa_pkg::BIT_RECEIVE_DONE];
		assign frame_error_flag[i]      = ferr_q[i];
		assign serial_mode[i*2 +: 2]    = pif.mode;
	end

	// ======================================================================
	// Next-state logic
	always_comb begin
		logic [7:0] ca;
		logic [7:0] nv;
		ca                     = 8'h00;
		nv                     = 8'h00;
		station_address_d      = station_address_q;
		station_address_mask_d = station_address_mask_q;
		power_ctrl_d           = power_ctrl_q;
		mode_high_d            = mode_high_q;
		ferr_d                 = ferr_q;
		rdata_d                = 8'h00;
		for (int i = 0; i < PORTS; i++) begin
			ctrl_d[i]  = ctrl_q[i];
			rxbuf_d[i] = rxbuf_q[i];
		end
		// Software writes go first so a same-cycle hardware event wins.
		if (reg_wr) begin
			unique case (reg_addr)
				ufa_pkg::ADDR_STATION_ADDRESS:   station_address_d = reg_wdata; // RQ14
				ufa_pkg::ADDR_STATION_ADDR_MASK: station_address_mask_d = reg_wdata; // RQ14
				ufa_pkg::ADDR_POWER_CTRL:        power_ctrl_d = reg_wdata;
				default: ;
			endcase
			for (int i = 0; i < PORTS; i++) begin
				ca = (i == 0) ? ufa_pkg::ADDR_SERIAL_CTRL : ufa_pkg::ADDR_PORT2_SERIAL_CTRL;
				if (reg_addr == ca) begin
					ctrl_d[i] = reg_wdata;
					if (view_fe) begin
						// Software may only clear the flag; writing a one leaves it as it was.
						ferr_d[i] = ferr_q[i] & reg_wdata[ufa_pkg::BIT_SHARED_VIEW]; // RQ2 RQ3 RQ4
					end else begin
						mode_high_d[i] = reg_wdata[ufa_pkg::BIT_SHARED_VIEW]; // RQ2 RQ3
					end
				end
			end
		end
		for (int i = 0; i < PORTS; i++) begin
			if (ferr_set[i]) begin
				ferr_d[i] = 1'b1; // RQ1 RQ4 RQ5
			end
			if (load[i]) begin
				rxbuf_d[i] = frame_data[i*8 +: 8]; // RQ15
				ctrl_d[i][ufa_pkg::BIT_RECEIVE_DONE] = 1'b1; // RQ15
				if ({mode_high_q[i], ctrl_q[i][ufa_pkg::BIT_MODE_LOW]} == ufa_pkg::MODE_ASYNC) begin
					ctrl_d[i][ufa_pkg::BIT_RX_NINTH] = frame_stop[i];
				end else begin
					ctrl_d[i][ufa_pkg::BIT_RX_NINTH] = frame_ninth[i]; // RQ16
				end
			end
		end
		if (reg_rd) begin
			unique case (reg_addr)
				ufa_pkg::ADDR_STATION_ADDRESS:   rdata_d = station_address_q;
				ufa_pkg::ADDR_STATION_ADDR_MASK: rdata_d = station_address_mask_q;
				ufa_pkg::ADDR_POWER_CTRL:        rdata_d = power_ctrl_q;
				ufa_pkg::ADDR_RX_BUFFER:         rdata_d = rxbuf_q[0];
				ufa_pkg::ADDR_PORT2_RX_BUFFER:   rdata_d = rxbuf_q[1];
				default: ;
			endcase
			for (int i = 0; i < PORTS; i++) begin
				ca = (i == 0) ? ufa_pkg::ADDR_SERIAL_CTRL : ufa_pkg::ADDR_PORT2_SERIAL_CTRL;
				if (reg_addr == ca) begin
					nv = ctrl_q[i];
					nv[ufa_pkg::BIT_SHARED_VIEW] = view_fe ? ferr_q[i] : mode_high_q[i]; // RQ2 RQ3
					rdata_d = nv;
				end
			end
		end
	end

	// ======================================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			station_address_q      <= ufa_pkg::RST_STATION_ADDRESS; // RQ13
			station_address_mask_q <= ufa_pkg::RST_STATION_ADDR_MASK; // RQ13
			power_ctrl_q           <= ufa_pkg::RST_POWER_CTRL;
			mode_high_q            <= '0;
			ferr_q                 <= '0;
			rdata_q                <= 8'h00;
			for (int i = 0; i < PORTS; i++) begin
				ctrl_q[i]  <= ufa_pkg::RST_SERIAL_CTRL;
				rxbuf_q[i] <= ufa_pkg::RST_RX_BUFFER;
			end
		end else begin
			station_address_q      <= station_address_d;
			station_address_mask_q <= station_address_mask_d;
			power_ctrl_q           <= power_ctrl_d;
			mode_high_q            <= mode_high_d;
			ferr_q                 <= ferr_d;
			rdata_q                <= rdata_d;
			for (int i = 0; i < PORTS; i++) begin
				ctrl_q[i]  <= ctrl_d[i];
				rxbuf_q[i] <= rxbuf_d[i];
			end
		end
	end

	assign reg_rdata = rdata_q;

endmodule : ufa_rx_ext

// ==== bench/ufa_rx_ext_monitor.sv ====
// Checker for the receive extension, bound to the top module.
module ufa_rx_ext_monitor #(
	parameter int PORTS = 2
) (
	input wire logic               clk_sys,
	input wire logic               rst,
	input wire logic [7:0]         reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [7:0]         reg_rdata,
	input wire logic [PORTS-1:0]   frame_done,
	input wire logic [PORTS-1:0]   frame_stop,
	input wire logic [PORTS-1:0]   receive_done_flag,
	input wire logic [PORTS-1:0]   frame_error_flag,
	input wire logic [PORTS*2-1:0] serial_mode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [7:0] sa_q;
	logic [7:0] sa_d;
	always_comb begin
		sa_d = sa_q;
		if (reg_wr && reg_addr == ufa_pkg::ADDR_STATION_ADDRESS) sa_d = reg_wdata;
		if (rst) sa_d = 8'h00;
	end
	always_ff @(posedge clk_sys) sa_q <= sa_d;
	property p_fe0_set; frame_done[0] && !frame_stop[0] && serial_mode[1:0] != 2'h0 |=> frame_error_flag[0]; endproperty
	a_fe0_set: assert property (p_fe0_set) else $error("port0 frame error not set");
	property p_fe1_set; frame_done[1] && !frame_stop[1] && serial_mode[3:2] != 2'h0 |=> frame_error_flag[1]; endproperty
	a_fe1_set: assert property (p_fe1_set) else $error("port2 frame error not set");
	property p_fe_hw; !frame_error_flag[0] && !(frame_done[0] && !frame_stop[0]) |=> !frame_error_flag[0]; endproperty
	a_fe_hw: assert property (p_fe_hw) else $error("frame error set without cause");
	property p_fe_hold; frame_error_flag[0] && !reg_wr |-> ##1 frame_error_flag[0]; endproperty
	a_fe_hold: assert property (p_fe_hold) else $error("frame error cleared by hardware");
	property p_ri_hold; receive_done_flag[0] && !reg_wr |=> receive_done_flag[0]; endproperty
	a_ri_hold: assert property (p_ri_hold) else $error("receive flag dropped");
	property p_ri_cause; !receive_done_flag[0] && !frame_done[0] && !reg_wr |=> !receive_done_flag[0]; endproperty
	a_ri_cause: assert property (p_ri_cause) else $error("receive flag without frame");
	property p_mode; !reg_wr |=> $stable(serial_mode); endproperty
	a_mode: assert property (p_mode) else $error("mode changed without write");
	property p_sa_rd; reg_rd && reg_addr == ufa_pkg::ADDR_STATION_ADDRESS |=> reg_rdata == sa_q; endproperty
	a_sa_rd: assert property (p_sa_rd) else $error("station address read wrong");
	c_fe: cover property (frame_done[0] && !frame_stop[0]);
	c_load: cover property ($rose(receive_done_flag[0]));
	c_fe1: cover property ($rose(frame_error_flag[1]));
endmodule : ufa_rx_ext_monitor

bind ufa_rx_ext ufa_rx_ext_monitor #(.PORTS(PORTS)) u_mon (.clk_sys(clk_sys), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .frame_done(frame_done), .frame_stop(frame_stop),
	.receive_done_flag(receive_done_flag), .frame_error_flag(frame_error_flag),
	.serial_mode(serial_mode));

// ==== bench/ufa_node_model.sv ====
// Far-side node model that hands finished frames to either receive lane.
module ufa_node_model (
	input  wire logic        clk_sys,
	output logic      [1:0]  frame_done,
	output logic      [15:0] frame_data,
	output logic      [1:0]  frame_ninth,
	output logic      [1:0]  frame_stop
);
	initial begin
		frame_done = 2'h0;
		frame_data = 16'h5A5A;
		frame_ninth = 2'h0;
		frame_stop = 2'h3;
	end
	// Between frames the lines carry the inverse of the last value so stale data never matches.
	task automatic send(input int p, input logic [7:0] d, input logic n, input logic s);
		@(posedge clk_sys);
		frame_done[p] <= 1'b1;
		frame_data[p*8 +: 8] <= d;
		frame_ninth[p] <= n;
		frame_stop[p] <= s;
		@(posedge clk_sys);
		frame_done[p] <= 1'b0;
		frame_data[p*8 +: 8] <= ~d;
		frame_ninth[p] <= ~n;
		frame_stop[p] <= ~s;
	endtask : send
endmodule : ufa_node_model

// ==== bench/tb.sv ====
// Testbench for the receive extension: register access, frames and flag checks.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CTL = ufa_pkg::ADDR_SERIAL_CTRL;
	localparam logic [7:0] CT2 = ufa_pkg::ADDR_PORT2_SERIAL_CTRL;
	localparam logic [7:0] PWR = ufa_pkg::ADDR_POWER_CTRL;
	localparam logic [17:0] TBL [7] = '{{8'hA0, 8'hA1, 2'h3}, {8'hA0, 8'hA3, 2'h2},
		{8'hE0, 8'hA5, 2'h3}, {8'hE0, 8'hFE, 2'h3}, {8'hA0, 8'hA1, 2'h0},
		{8'h80, 8'hA3, 2'h1}, {8'hE0, 8'h5F, 2'h2}};
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic [1:0]  fd, fn, fs, rdf, fef;
	logic [15:0] fdat;
	logic [3:0]  smode;
	int          mismatches = 0;
	int          cmp_count = 0;
	always #25 clk_sys = ~clk_sys;
	ufa_rx_ext #(.PORTS(2)) DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_done(fd), .frame_data(fdat), .frame_ninth(fn), .frame_stop(fs),
		.receive_done_flag(rdf), .frame_error_flag(fef), .serial_mode(smode));
	ufa_node_model node (.clk_sys(clk_sys), .frame_done(fd), .frame_data(fdat),
		.frame_ninth(fn), .frame_stop(fs));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("reg_rdata", exp, reg_rdata);
	endtask : rd
	task automatic flags(input logic [1:0] ri, input logic [1:0] fe);
		@(negedge clk_sys);
		chk("receive_done_flag", {6'h00, ri}, {6'h00, rdf});
		chk("frame_error_flag", {6'h00, fe}, {6'h00, fef});
	endtask : flags
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#100us;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ufa_pkg::ADDR_STATION_ADDRESS, 8'h00);
		rd(ufa_pkg::ADDR_STATION_ADDR_MASK, 8'h00);
		rd(8'h10, 8'h00);
		wr(CTL, 8'hA0);
		node.send(0, 8'h37, 1'b1, 1'b1);
		flags(2'b01, 2'b00);
		rd(CTL, 8'hA5);
		node.send(0, 8'h99, 1'b1, 1'b1);
		rd(ufa_pkg::ADDR_RX_BUFFER, 8'h37);
		$display("test reset_match done");
		wr(ufa_pkg::ADDR_STATION_ADDRESS, 8'hA4);
		wr(ufa_pkg::ADDR_STATION_ADDR_MASK, 8'hFA);
		rd(ufa_pkg::ADDR_STATION_ADDRESS, 8'hA4);
		rd(ufa_pkg::ADDR_STATION_ADDR_MASK, 8'hFA);
		for (int i = 0; i < 7; i++) begin
			wr(CTL, TBL[i][17:10]);
			node.send(0, TBL[i][9:2], TBL[i][1], 1'b1);
			flags({1'b0, TBL[i][0]}, 2'b00);
		end
		$display("test address_match done");
		wr(CTL, 8'h60);
		node.send(0, 8'hA1, 1'b0, 1'b0);
		flags(2'b00, 2'b01);
		node.send(0, 8'hFE, 1'b0, 1'b1);
		flags(2'b01, 2'b01);
		wr(PWR, 8'h40);
		rd(CTL, 8'hE5);
		wr(CTL, 8'h60);
		flags(2'b00, 2'b00);
		wr(CTL, 8'hE0);
		flags(2'b00, 2'b00);
		chk("serial_mode", 8'h01, {4'h0, smode});
		wr(PWR, 8'h00);
		rd(CTL, 8'h60);
		$display("test frame_error done");
		wr(CT2, 8'h40);
		node.send(1, 8'h5A, 1'b0, 1'b0);
		flags(2'b10, 2'b10);
		wr(PWR, 8'h40);
		rd(CT2, 8'hC1);
		wr(CT2, 8'h40);
		flags(2'b00, 2'b00);
		$display("test second_port done");
		give_verdict();
	end
endmodule : tb
